// ===== rtl/pbs_host.sv
// Controller end of the burst SRAM bus: single writes, read bursts.
// Assumes pbs_dev on the same pbs_if and clock.
`timescale 1ns/1ps
`include "pbs_defs.svh"

module pbs_host #(
    parameter int ADDR_W = `PBS_ADDR_W,
    parameter int LANES = `PBS_LANES,
    parameter int LANE_W = `PBS_LANE_W,
    parameter bit LINEAR = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    pbs_if.host bus,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [LANES-1:0] req_lanes,
    input wire pbs_pkg::pbs_cnt_t req_beats,
    input wire logic [LANES*LANE_W-1:0] req_wdata,
    input wire logic read_stall,
    input wire logic snooze_in,
    output logic [LANES*LANE_W-1:0] rdata,
    output logic rvalid
);
    import pbs_pkg::*;

    localparam int W = LANES * LANE_W;

    pbs_hstate_t st_q, st_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic pstr_n_q, pstr_n_d, cstr_n_q, cstr_n_d, step_n_q, step_n_d;
    logic gate_n_q, gate_n_d, all_n_q, all_n_d;
    logic [LANES-1:0] sel_n_q, sel_n_d;
    logic [2:0] cs_q, cs_d;
    logic snz_q, snz_d, oe_n_q, oe_n_d, hoe_n_q, hoe_n_d, rdy_q, rdy_d, rv_q, rv_d;
    logic [W-1:0] hdata_q, hdata_d, rdata_q, rdata_d;
    pbs_cnt_t left_q, left_d;
    logic [`PBS_RD_LAT-1:0] pipe_q, pipe_d;

    // Sequencer: idle cycles deselect, so the SRAM lets go of the bus
    always_comb begin
        st_d = st_q;
        addr_d = addr_q;
        left_d = left_q;
        pstr_n_d = 1'b1;
        cstr_n_d = 1'b0;
        step_n_d = 1'b1;
        gate_n_d = 1'b1;
        all_n_d = 1'b1;
        sel_n_d = '1;
        cs_d = `PBS_CS_OFF;
        snz_d = 1'b0;
        oe_n_d = 1'b1;
        hoe_n_d = 1'b1;
        hdata_d = hdata_q;
        rdy_d = 1'b0;
        pipe_d = {pipe_q[`PBS_RD_LAT-2:0], 1'b0};
        rv_d = pipe_q[`PBS_RD_LAT-1];
        rdata_d = pipe_q[`PBS_RD_LAT-1] ? bus.data_lanes : rdata_q;
        case (st_q)
            PBS_IDLE: begin
                rdy_d = !snooze_in;
                if (req_valid && rdy_q) begin
                    rdy_d = 1'b0;
                    addr_d = req_addr; // Low bits carry the burst start
                    cs_d = `PBS_CS_ON;
                    if (req_write) begin
                        // Controller strobe so the write lands now
                        if (&req_lanes) begin
                            all_n_d = 1'b0;
                        end else begin
                            gate_n_d = 1'b0; // Gate with lane selects
                            sel_n_d = ~req_lanes;
                        end
                        hdata_d = req_wdata;
                        hoe_n_d = 1'b0; // Output drive stays off meanwhile
                    end else begin
                        pstr_n_d = 1'b0;
                        cstr_n_d = 1'b1;
                        oe_n_d = 1'b0;
                        pipe_d[0] = 1'b1;
                        left_d = req_beats;
                        st_d = (req_beats != '0) ? PBS_READ : PBS_DRAIN;
                    end
                end else begin
                    snz_d = snooze_in; // Standby only between requests
                end
            end
            PBS_READ: begin
                cs_d = `PBS_CS_ON;
                cstr_n_d = 1'b1;
                oe_n_d = 1'b0;
                if (!read_stall) begin
                    step_n_d = 1'b0; // Advance to the next burst word
                    pipe_d[0] = 1'b1;
                    left_d = left_q - 2'h1;
                    if (left_q == 2'h1) begin
                        st_d = PBS_DRAIN;
                    end
                end // Stall: strobes and step held off, a wait state
            end
            PBS_DRAIN: begin
                // Hold output drive until the last word is sampled; the
                // bus is free the edge after, so a write may follow
                oe_n_d = 1'b0;
                if (pipe_q[`PBS_RD_LAT-2:0] == '0) begin
                    oe_n_d = 1'b1;
                    rdy_d = !snooze_in;
                    st_d = PBS_IDLE;
                end
            end
            default: begin
                st_d = PBS_IDLE;
            end
        endcase
    end

    // Pin and user-side registers
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= PBS_IDLE;
            addr_q <= '0;
            left_q <= '0;
            pstr_n_q <= 1'b1;
            cstr_n_q <= 1'b1;
            step_n_q <= 1'b1;
            gate_n_q <= 1'b1;
            all_n_q <= 1'b1;
            sel_n_q <= '1;
            cs_q <= `PBS_CS_OFF;
            snz_q <= 1'b0;
            oe_n_q <= 1'b1;
            hoe_n_q <= 1'b1;
            hdata_q <= '0;
            rdy_q <= 1'b0;
            pipe_q <= '0;
            rv_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            st_q <= st_d;
            addr_q <= addr_d;
            left_q <= left_d;
            pstr_n_q <= pstr_n_d;
            cstr_n_q <= cstr_n_d;
            step_n_q <= step_n_d;
            gate_n_q <= gate_n_d;
            all_n_q <= all_n_d;
            sel_n_q <= sel_n_d;
            cs_q <= cs_d;
            snz_q <= snz_d;
            oe_n_q <= oe_n_d;
            hoe_n_q <= hoe_n_d;
            hdata_q <= hdata_d;
            rdy_q <= rdy_d;
            pipe_q <= pipe_d;
            rv_q <= rv_d;
            rdata_q <= rdata_d;
        end
    end

    assign bus.addr = addr_q;
    assign bus.processor_addr_strobe_n = pstr_n_q;
    assign bus.controller_addr_strobe_n = cstr_n_q;
    assign bus.burst_step_request_n = step_n_q;
    assign bus.byte_write_gate_n = gate_n_q;
    assign bus.lane_write_selects_n = sel_n_q;
    assign bus.all_lanes_write_n = all_n_q;
    assign bus.chip_selects = cs_q;
    assign bus.snooze_request = snz_q;
    assign bus.burst_order = !LINEAR; // Strap: high means interleaved
    assign bus.output_drive_n = oe_n_q;
    assign bus.host_data = hdata_q;
    assign bus.host_data_oe_n = hoe_n_q;
    assign req_ready = rdy_q;
    assign rdata = rdata_q;
    assign rvalid = rv_q;

endmodule

// ===== rtl/pbs_defs.svh
// Constants shared by the burst SRAM model, its bus and its controller.
// Assumes both ends run on one clock and include this file by its bare name.
//
// Overview of operation
// - Memory registers every synchronous input on rising edge
// - Write starts at its edge, then self-timed
// - A write updates one to four lanes
// - Lane writes need gate plus lane selects
// - All-lanes write writes every lane regardless
// - Either address strobe starts a burst
// - Burst address steps only while step asserted
// - Order pin: low linear, high interleaved
// - Burst counter is two bits wide
// - Burst low bits are address bus LSBs
// - One shared bidirectional data bus
// - Array is 512Kx32, 512Kx36 or 1Mx18
// - Parity bit travels with its data lane
// - Pipelined reads, bus released one cycle after deselect
// - Snooze request gives standby without accesses
// - Processor strobe always reads; write follows next edge
// - Wait states hold strobes and step inactive
// - Output drive stays off around write capture
`ifndef PBS_DEFS_SVH
`define PBS_DEFS_SVH

// Default organisation: 512K words of four 9-bit lanes
`define PBS_ADDR_W 19
`define PBS_LANES 4
`define PBS_LANE_W 9
// Parity position inside a 9-bit lane
`define PBS_PAR_BIT 8
// Burst counter width
`define PBS_CNT_W 2
// Chip select patterns {select2 low, select2 high, select1 low}
`define PBS_CS_ON 3'h2
`define PBS_CS_OFF 3'h5
// Edges from read issue to sampling the data at the controller
`define PBS_RD_LAT 3

`endif

// ===== rtl/pbs_pkg.sv
// Types shared by the burst SRAM model and its controller.
// Assumes pbs_defs.svh is on the include path.
`include "pbs_defs.svh"

package pbs_pkg;
    // Burst counter value and beat count
    typedef logic [`PBS_CNT_W-1:0] pbs_cnt_t;
    // Controller sequencer states, one-hot
    typedef enum logic [3:0] {
        PBS_IDLE = 4'h1,
        PBS_READ = 4'h2,
        PBS_DRAIN = 4'h4,
        PBS_SPARE = 4'h8
    } pbs_hstate_t;
endpackage

// ===== rtl/pbs_if.sv
// Pin-level bus between the burst SRAM and the controller that drives it.
// Assumes one shared clock; the data wire is resolved here from both enables.
`timescale 1ns/1ps
`include "pbs_defs.svh"

interface pbs_if #(
    parameter int ADDR_W = `PBS_ADDR_W,
    parameter int LANES = `PBS_LANES,
    parameter int LANE_W = `PBS_LANE_W
);
    logic [ADDR_W-1:0] addr;
    logic processor_addr_strobe_n;
    logic controller_addr_strobe_n;
    logic burst_step_request_n;
    logic byte_write_gate_n;
    logic [LANES-1:0] lane_write_selects_n;
    logic all_lanes_write_n;
    logic [2:0] chip_selects;
    logic snooze_request;
    logic burst_order;
    logic output_drive_n;
    logic [LANES*LANE_W-1:0] host_data;
    logic host_data_oe_n;
    logic [LANES*LANE_W-1:0] dev_data;
    logic dev_data_oe_n;
    logic [LANES*LANE_W-1:0] data_lanes;

    // Shared data wire; an undriven bus floats high like a weak pull-up
    assign data_lanes = !dev_data_oe_n ? dev_data : (!host_data_oe_n ? host_data : '1);

    modport device (
        input addr, processor_addr_strobe_n, controller_addr_strobe_n,
        input burst_step_request_n, byte_write_gate_n, lane_write_selects_n,
        input all_lanes_write_n, chip_selects, snooze_request, burst_order,
        input output_drive_n, data_lanes,
        output dev_data, dev_data_oe_n
    );
    modport host (
        output addr, processor_addr_strobe_n, controller_addr_strobe_n,
        output burst_step_request_n, byte_write_gate_n, lane_write_selects_n,
        output all_lanes_write_n, chip_selects, snooze_request, burst_order,
        output output_drive_n, host_data, host_data_oe_n,
        input data_lanes
    );
endinterface

// ===== rtl/pbs_dev.sv
// Pipelined burst SRAM with single-cycle deselect, storage in flip-flops.
// Assumes the controller on pbs_if shares clk and keeps the bus protocol.
`timescale 1ns/1ps
`include "pbs_defs.svh"

module pbs_dev #(
    parameter int ADDR_W = `PBS_ADDR_W,
    parameter int LANES = `PBS_LANES,
    parameter int LANE_W = `PBS_LANE_W
) (
    input wire logic clk,
    input wire logic rst,
    pbs_if.device bus
);
    import pbs_pkg::*;

    // Organisation is set by the three parameters
    localparam int W = LANES * LANE_W;
    localparam int DEPTH = 1 << ADDR_W;

    // Input capture registers
    logic [ADDR_W-1:0] addr_q;
    logic pstrobe_n_q;
    logic cstrobe_n_q;
    logic step_n_q;
    logic gate_n_q;
    logic [LANES-1:0] sel_n_q;
    logic all_n_q;
    logic [2:0] cs_q;
    logic snooze_q;
    logic order_q;
    logic [W-1:0] wdata_q;

    // Burst and pipeline state
    logic active_q;
    logic active_d;
    pbs_cnt_t cnt_q;
    pbs_cnt_t cnt_d;
    logic [ADDR_W-1:0] base_q;
    logic [ADDR_W-1:0] base_d;
    logic [W-1:0] dout_q;
    logic [W-1:0] dout_d;
    logic oe_n_q;
    logic oe_n_d;

    // Storage and its write port
    logic [W-1:0] mem [DEPTH];
    logic mem_we;
    logic [ADDR_W-1:0] eaddr;
    logic [W-1:0] wword;

    // Decode helpers
    logic chip_on;
    logic strobe;
    logic begin_p;
    logic acc;
    logic is_write;
    logic [LANES-1:0] lane_we;
    pbs_cnt_t low;

    // Every synchronous pin lands in a register first; output drive is left
    // out because it acts on the cycle it is seen, as on the real part
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_q <= '0;
            pstrobe_n_q <= 1'b1;
            cstrobe_n_q <= 1'b1;
            step_n_q <= 1'b1;
            gate_n_q <= 1'b1;
            sel_n_q <= '1;
            all_n_q <= 1'b1;
            cs_q <= `PBS_CS_OFF;
            snooze_q <= 1'b0;
            order_q <= 1'b1;
            wdata_q <= '0;
        end else begin
            addr_q <= bus.addr;
            pstrobe_n_q <= bus.processor_addr_strobe_n;
            cstrobe_n_q <= bus.controller_addr_strobe_n;
            step_n_q <= bus.burst_step_request_n;
            gate_n_q <= bus.byte_write_gate_n;
            sel_n_q <= bus.lane_write_selects_n;
            all_n_q <= bus.all_lanes_write_n;
            cs_q <= bus.chip_selects;
            snooze_q <= bus.snooze_request;
            order_q <= bus.burst_order; // Strap, caught each edge after reset
            wdata_q <= bus.data_lanes;
        end
    end

    // Cycle decode, burst address generation and memory access
    always_comb begin
        chip_on = (cs_q == `PBS_CS_ON);
        // Global write wins over the gate and the lane selects
        if (!all_n_q) begin
            lane_we = '1;
        end else if (!gate_n_q) begin
            lane_we = ~sel_n_q; // Lanes picked by gate plus selects
        end else begin
            lane_we = '0;
        end
        // The processor strobe is ignored while the primary select is off
        begin_p = !pstrobe_n_q && !cs_q[0];
        strobe = begin_p || !cstrobe_n_q; // Either strobe loads an address
        active_d = active_q;
        cnt_d = cnt_q;
        base_d = base_q;
        acc = 1'b0;
        is_write = 1'b0;
        if (snooze_q) begin
            // Standby: no access, burst forgotten, bus released
            active_d = 1'b0;
        end else if (strobe) begin
            if (chip_on) begin
                // Begin burst from the external address
                acc = 1'b1;
                active_d = 1'b1;
                base_d = addr_q;
                cnt_d = '0;
                // A processor-strobe start is always a read
                is_write = !begin_p && (|lane_we);
            end else begin
                active_d = 1'b0; // Deselect
            end
        end else if (active_q) begin
            // Continue or suspend; only the step input moves the count
            acc = 1'b1;
            is_write = |lane_we;
            if (!step_n_q) begin
                cnt_d = cnt_q + 2'h1; // Two-bit count wraps after four
            end
        end
        // Low address bits follow the strapped order
        if (order_q) begin
            low = pbs_cnt_t'(base_d[`PBS_CNT_W-1:0]) ^ cnt_d;
        end else begin
            low = pbs_cnt_t'(base_d[`PBS_CNT_W-1:0]) + cnt_d;
        end
        // The counter only replaces the bus LSBs
        eaddr = {base_d[ADDR_W-1:`PBS_CNT_W], low};
        // Merge enabled lanes into the stored word; parity rides in the
        // top bit of each lane and is written with it
        wword = mem[eaddr];
        for (int l = 0; l < LANES; l++) begin
            if (lane_we[l]) begin
                wword[l*LANE_W +: LANE_W] = wdata_q[l*LANE_W +: LANE_W];
            end
        end
        // Self-timed: written at the edge after capture, no more strobes
        mem_we = acc && is_write;
        // Registered read output, one edge after the address edge
        dout_d = (acc && !is_write) ? mem[eaddr] : dout_q;
        // Drive only for a read with output drive on; a deselect or a write
        // releases the bus at the very next edge
        oe_n_d = !(acc && !is_write && !bus.output_drive_n);
    end

    // Burst and output pipeline registers
    always_ff @(posedge clk) begin
        if (rst) begin
            active_q <= 1'b0;
            cnt_q <= '0;
            base_q <= '0;
            dout_q <= '0;
            oe_n_q <= 1'b1;
        end else begin
            active_q <= active_d;
            cnt_q <= cnt_d;
            base_q <= base_d;
            dout_q <= dout_d;
            oe_n_q <= oe_n_d;
        end
    end

    // Storage array; contents are not reset, like a real SRAM
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[eaddr] <= wword;
        end
    end

    // One shared data bus for reads and writes
    assign bus.dev_data = dout_q;
    assign bus.dev_data_oe_n = oe_n_q;

endmodule

// ===== tb/pbs_bus_asserts.sv
// Concurrent checks on the pin bus between the burst SRAM and its controller.
// Assumes the signals of the first pbs_if, one clock and a synchronous reset.
`timescale 1ns/1ps
`include "pbs_defs.svh"

module pbs_bus_asserts #(
    parameter int LANES = 4,
    parameter bit LINEAR = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic byte_write_gate_n,
    input wire logic [LANES-1:0] lane_write_selects_n,
    input wire logic all_lanes_write_n,
    input wire logic [2:0] chip_selects,
    input wire logic snooze_request,
    input wire logic burst_order,
    input wire logic output_drive_n,
    input wire logic host_data_oe_n,
    input wire logic dev_data_oe_n
);
    // Any write control active in this cycle
    wire logic wr_ctl = !all_lanes_write_n || !byte_write_gate_n;

    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Ranges allow for the input register stage before the pipeline
    AST_DESEL_FREE: assert property (
        !controller_addr_strobe_n && chip_selects != `PBS_CS_ON |-> ##[2:3] dev_data_oe_n)
        else $error("data bus still driven after deselect");
    AST_READ_DRIVE: assert property (
        !processor_addr_strobe_n && chip_selects == `PBS_CS_ON && !snooze_request
        |-> ##[2:3] !dev_data_oe_n) else $error("read word never driven");
    AST_OE_CAUSE: assert property (
        !dev_data_oe_n |-> !$past(output_drive_n))
        else $error("device drove without output drive");
    AST_NO_FIGHT: assert property (
        !(!dev_data_oe_n && !host_data_oe_n)) else $error("both ends drive the data bus");
    AST_PSTROBE_READ: assert property (
        !processor_addr_strobe_n |-> all_lanes_write_n && byte_write_gate_n)
        else $error("write controls with processor strobe");
    AST_WRITE_CYCLE: assert property (
        wr_ctl |-> !controller_addr_strobe_n && chip_selects == `PBS_CS_ON && !host_data_oe_n)
        else $error("write not framed by controller strobe");
    AST_WRITE_ONE: assert property (
        wr_ctl |=> !wr_ctl) else $error("write controls held past one cycle");
    AST_GATE_LANE: assert property (
        !byte_write_gate_n |-> lane_write_selects_n != '1 && all_lanes_write_n)
        else $error("byte gate without a lane select");
    AST_ORDER_PIN: assert property (
        burst_order == !LINEAR) else $error("burst order pin wrong");
    AST_SNOOZE_FREE: assert property (
        snooze_request |-> ##[1:3] dev_data_oe_n) else $error("bus driven in snooze");
endmodule

// ===== tb/tb_top.sv
// Self-checking bench: two SRAM/controller pairs, interleaved and linear.
// Assumes the design files under rtl/ are compiled first.
`timescale 1ns/1ps

module tb_top;
    import pbs_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid, req_write, read_stall, snooze_in;
    logic [18:0] req_addr;
    logic [3:0] req_lanes;
    pbs_cnt_t req_beats;
    logic [35:0] req_wdata;
    logic [1:0] req_ready, rvalid;
    logic [35:0] rdata [2];
    logic [35:0] mem [8];
    logic [15:0] base;
    int seed = 81;
    int failures = 0;
    int n_tests = 0;

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    // End 0 interleaved and checked on the wire, end 1 linear
    for (genvar g = 0; g < 2; g++) begin : g_end
        pbs_if pbs_if_inst ();
        pbs_dev pbs_dev_inst (.clk(clk), .rst(rst), .bus(pbs_if_inst));
        pbs_host #(.LINEAR(g == 1)) pbs_host_inst (.clk(clk), .rst(rst), .bus(pbs_if_inst),
            .req_valid(req_valid), .req_ready(req_ready[g]), .req_write(req_write),
            .req_addr(req_addr), .req_lanes(req_lanes), .req_beats(req_beats),
            .req_wdata(req_wdata), .read_stall(read_stall), .snooze_in(snooze_in),
            .rdata(rdata[g]), .rvalid(rvalid[g]));
        if (g == 0) begin : g_chk
            pbs_bus_asserts #(.LANES(4), .LINEAR(1'b0)) pbs_bus_asserts_inst (.clk(clk),
                .rst(rst), .processor_addr_strobe_n(pbs_if_inst.processor_addr_strobe_n),
                .controller_addr_strobe_n(pbs_if_inst.controller_addr_strobe_n),
                .byte_write_gate_n(pbs_if_inst.byte_write_gate_n),
                .lane_write_selects_n(pbs_if_inst.lane_write_selects_n),
                .all_lanes_write_n(pbs_if_inst.all_lanes_write_n),
                .chip_selects(pbs_if_inst.chip_selects),
                .snooze_request(pbs_if_inst.snooze_request),
                .burst_order(pbs_if_inst.burst_order),
                .output_drive_n(pbs_if_inst.output_drive_n),
                .host_data_oe_n(pbs_if_inst.host_data_oe_n),
                .dev_data_oe_n(pbs_if_inst.dev_data_oe_n));
        end
    end

    // Burst word k from region index i; linear adds, interleaved XORs
    function automatic logic [35:0] exp_word(bit lin, logic [2:0] i, logic [1:0] k);
        logic [1:0] lo;
        lo = lin ? i[1:0] + k : i[1:0] ^ k;
        return mem[{i[2], lo}];
    endfunction

    task automatic check_data(logic [35:0] got, logic [35:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_flag(logic got, logic exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic hang();
        failures++;
        $display("mismatch at %0t: wait limit used up", $time);
        final_report();
    endtask

    // One request to both ends; writes update the model, reads are checked
    task automatic issue(logic wr, logic [2:0] i, logic [3:0] ln, logic [1:0] bt, logic st);
        int t;
        t = 0;
        do begin
            @(negedge clk);
            read_stall = 1'b0;
            t++;
            if (t > 50) hang();
        end while (req_ready !== 2'h3);
        req_valid = 1'b1;
        req_write = wr;
        req_addr = {base[15:0], i};
        req_lanes = ln;
        req_beats = bt;
        req_wdata = 36'({$random(seed), $random(seed)});
        @(negedge clk);
        req_valid = 1'b0;
        if (wr) begin
            for (int l = 0; l < 4; l++) begin
                if (ln[l]) mem[i][l*9 +: 9] = req_wdata[l*9 +: 9];
            end
        end else begin
            for (int k = 0; k <= bt; k++) begin
                t = 0;
                do begin
                    @(negedge clk);
                    read_stall = st & 1'($random(seed));
                    t++;
                end while (rvalid !== 2'h3 && t < 20);
                if (rvalid !== 2'h3) hang();
                // First word lands three edges after the take, later words back to back
                if (!st) check_flag(t == (k == 0 ? 3 : 1), 1'b1);
                check_data(rdata[0], exp_word(1'b0, i, 2'(k)));
                check_data(rdata[1], exp_word(1'b1, i, 2'(k)));
            end
        end
    endtask

    // Full four-beat bursts from every start, wrapping inside the group
    task automatic read_all();
        for (int i = 0; i < 8; i++) issue(1'b0, 3'(i), 4'h0, 2'h3, 1'b0);
    endtask

    // Main sequence
    initial begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = '0;
        req_lanes = 4'h0;
        req_beats = 2'h0;
        req_wdata = '0;
        read_stall = 1'b0;
        snooze_in = 1'b0;
        base = 16'($random(seed));
        repeat (4) @(negedge clk);
        rst = 1'b0;
        // Whole words first so no read meets unwritten storage
        for (int i = 0; i < 8; i++) issue(1'b1, 3'(i), 4'hf, 2'h0, 1'b0);
        issue(1'b1, 3'h0, 4'h1, 2'h0, 1'b0);
        issue(1'b1, 3'h7, 4'h8, 2'h0, 1'b0);
        read_all();
        // Mixed traffic: partial writes, short and stalled bursts back to back
        for (int n = 0; n < 40; n++) begin
            if ($random(seed) % 2) begin
                issue(1'b1, 3'($random(seed)), 4'($random(seed)) | 4'h2, 2'h0, 1'b0);
            end else begin
                issue(1'b0, 3'($random(seed)), 4'h0, 2'($random(seed)), 1'b1);
            end
        end
        // Snooze refuses requests and must not disturb storage
        @(negedge clk);
        snooze_in = 1'b1;
        @(negedge clk);
        // Whole-word write offered while asleep; if taken, read_all would see it
        req_valid = 1'b1;
        req_write = 1'b1;
        req_lanes = 4'hf;
        repeat (3) @(negedge clk);
        check_flag(req_ready[0], 1'b0);
        check_flag(g_end[0].pbs_if_inst.snooze_request, 1'b1);
        req_valid = 1'b0;
        snooze_in = 1'b0;
        read_all();
        // Reset in mid-run clears the controller but not the array
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        check_flag(req_ready[1], 1'b0);
        rst = 1'b0;
        read_all();
        final_report();
    end
endmodule
